// ### src/rtcw_map.svh
// Register offsets, field positions, reset values and divider taps
// Assumes inclusion by bare name from the design files
`ifndef RTCW_MAP_SVH
`define RTCW_MAP_SVH

// Register pointer offsets (4-bit pointer space)
`define RTCW_OFS_HOUR 4'ha
`define RTCW_OFS_DATE 4'hb
`define RTCW_OFS_WDAY 4'hc
`define RTCW_OFS_SQW 4'hd

// Field positions
`define RTCW_DIS_BIT 7
`define RTCW_SQW_GATE_BIT 7
`define RTCW_HOUR_MSB 5
`define RTCW_DATE_MSB 5
`define RTCW_WDAY_MSB 2
`define RTCW_RATE_MSB 1

// Reset values
`define RTCW_RST_DIS 1'h1
`define RTCW_RST_HOUR 6'h00
`define RTCW_RST_DATE 6'h00
`define RTCW_RST_WDAY 3'h0
`define RTCW_RST_GATE 1'h1
`define RTCW_RST_RATE 2'h0

// Prescaler taps on 32.768 kHz edges: /32, /1024, /32768
`define RTCW_TAP_1024HZ 4
`define RTCW_TAP_32HZ 9
`define RTCW_TAP_1HZ 14

// Serial bus slave address, arbitrary value
`define RTCW_SLAVE_ADDR 7'h2a

`endif

// ### src/rtcw_pkg.sv
// Types shared by the serial slave and square-wave logic
// Assumes rtcw_map.svh holds all numeric constants
package rtcw_pkg;

    // Serial slave states, one-hot
    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_ADDR = 9'h002,
        ST_AACK = 9'h004,
        ST_PTR = 9'h008,
        ST_PACK = 9'h010,
        ST_WDAT = 9'h020,
        ST_WACK = 9'h040,
        ST_RDAT = 9'h080,
        ST_RACK = 9'h100
    } rtcw_state_type;

    // Square-wave rate codes
    typedef enum logic [1:0] {
        RATE_32K = 2'h0,
        RATE_1024 = 2'h1,
        RATE_32 = 2'h2,
        RATE_1 = 2'h3
    } rtcw_rate_type;

endpackage : rtcw_pkg

// ### src/rtcw_sqw_gen.sv
// Square-wave generator from the oscillator level
// Assumes i_osc synchronous and slower than half the clock
`timescale 1ns/10ps
`include "rtcw_map.svh"

module rtcw_sqw_gen (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_osc,
    input wire logic i_gate,
    input wire logic i_pin_enable,
    input wire rtcw_pkg::rtcw_rate_type i_rate,
    output logic o_wave
);

    logic osc_q;         // Previous oscillator level
    logic osc_d;
    logic [14:0] div_q;  // Prescaler, counts oscillator rising edges
    logic [14:0] div_d;
    logic wave_q;        // Registered output
    logic wave_d;
    logic sel;           // Selected raw wave

    // Next values: prescaler, rate pick, gating
    always_comb
    begin
        osc_d = i_osc;
        div_d = div_q;
        if (i_osc && !osc_q)
        begin
            div_d = div_q + 15'h0001;
        end
        case (i_rate) // [RULE9]
            rtcw_pkg::RATE_32K: sel = osc_q;
            rtcw_pkg::RATE_1024: sel = div_q[`RTCW_TAP_1024HZ];
            rtcw_pkg::RATE_32: sel = div_q[`RTCW_TAP_32HZ];
            rtcw_pkg::RATE_1: sel = div_q[`RTCW_TAP_1HZ];
            default: sel = 1'b0;
        endcase
        // Register bit and pin must both allow it
        wave_d = i_gate & i_pin_enable & sel; // [RULE7]
    end

    // Registers only
    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            osc_q <= 1'b0;
            div_q <= 15'h0000;
            wave_q <= 1'b0;
        end
        else
        begin
            osc_q <= osc_d;
            div_q <= div_d;
            wave_q <= wave_d;
        end
    end

    assign o_wave = wave_q;

endmodule : rtcw_sqw_gen

// ### src/rtcw_alarm_square_wave_output.sv
// Alarm match registers, square-wave control, serial port
// Assumes scl/sda levels already synchronous to i_ref_clk, 10 MHz
// What this block does
// [RULE1] Hour match disable bit7, resets to one
// [RULE2] Hour value BCD bits 5:0, 00-23
// [RULE3] Date match disable bit7, resets to one
// [RULE4] Date value BCD bits 5:0, 01-31
// [RULE5] Weekday match disable bit7, resets to one
// [RULE6] Weekday value bits 2:0, 0-6
// [RULE7] Output needs register gate and enable pin
// [RULE8] Gate zero holds output low; resets one
// [RULE9] Rate select: 32k, 1024, 32, 1 Hz
// [RULE10] Unused control bits have no effect
// [RULE11] Alarm when all enabled fields match, none when all are disabled
`timescale 1ns/10ps
`include "rtcw_map.svh"

module rtcw_alarm_square_wave_output (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe,
    input wire logic [5:0] i_cur_hour,
    input wire logic [5:0] i_cur_date,
    input wire logic [2:0] i_cur_wday,
    input wire logic i_osc_32k,
    input wire logic i_square_wave_pin_enable,
    output logic o_alarm_match,
    output logic o_square_wave_output
);

    // Bus edge history
    logic scl_q;
    logic sda_q;

    // Serial slave state
    rtcw_pkg::rtcw_state_type state_q;
    rtcw_pkg::rtcw_state_type state_d;
    logic [3:0] cnt_q;     // Bit counter within a byte
    logic [3:0] cnt_d;
    logic [7:0] shift_q;   // Shift register, both directions
    logic [7:0] shift_d;
    logic [3:0] ptr_q;     // Register pointer, wraps at 0xf
    logic [3:0] ptr_d;
    logic rw_q;            // High for a read transfer
    logic rw_d;
    logic oe_q;            // Open-drain pull-down enable
    logic oe_d;
    logic sda_out_q;       // Driven level, always low

    // One-cycle write strobe
    logic wr_en;
    logic [7:0] rd_byte;

    // Bus events
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    // Register file fields
    logic hour_match_disable_q;
    logic hour_match_disable_d;
    logic [5:0] hour_val_q;
    logic [5:0] hour_val_d;
    logic day_of_month_match_disable_q;
    logic day_of_month_match_disable_d;
    logic [5:0] date_val_q;
    logic [5:0] date_val_d;
    logic day_of_week_match_disable_q;
    logic day_of_week_match_disable_d;
    logic [2:0] wday_val_q;
    logic [2:0] wday_val_d;
    logic square_wave_gate_q;
    logic square_wave_gate_d;
    rtcw_pkg::rtcw_rate_type square_wave_rate_select_q;
    rtcw_pkg::rtcw_rate_type square_wave_rate_select_d;

    // Alarm comparison
    logic alarm_q;
    logic alarm_d;

    assign scl_rise = i_scl & ~scl_q;
    assign scl_fall = ~i_scl & scl_q;
    assign bus_start = scl_q & i_scl & sda_q & ~i_sda;
    assign bus_stop = scl_q & i_scl & ~sda_q & i_sda;

    // Read mux; unused bits read as zero
    always_comb
    begin
        case (ptr_q)
            `RTCW_OFS_HOUR: rd_byte = {hour_match_disable_q, 1'b0, hour_val_q};
            `RTCW_OFS_DATE: rd_byte = {day_of_month_match_disable_q, 1'b0, date_val_q};
            `RTCW_OFS_WDAY: rd_byte = {day_of_week_match_disable_q, 4'h0, wday_val_q};
            `RTCW_OFS_SQW: rd_byte = {square_wave_gate_q, 5'h00, square_wave_rate_select_q};
            // Other registers read zero
            default: rd_byte = 8'h00;
        endcase
    end

    // Serial slave next state
    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        shift_d = shift_q;
        ptr_d = ptr_q;
        rw_d = rw_q;
        oe_d = oe_q;
        wr_en = 1'b0;
        if (bus_start)
        begin
            // Any start restarts addressing
            state_d = rtcw_pkg::ST_ADDR;
            cnt_d = 4'h0;
            oe_d = 1'b0;
        end
        else if (bus_stop)
        begin
            state_d = rtcw_pkg::ST_IDLE;
            oe_d = 1'b0;
        end
        else
        begin
            case (state_q)
                rtcw_pkg::ST_IDLE:
                begin
                    oe_d = 1'b0;
                end
                rtcw_pkg::ST_ADDR, rtcw_pkg::ST_PTR, rtcw_pkg::ST_WDAT:
                begin
                    // Sample on rising clock, act after the eighth bit
                    if (scl_rise)
                    begin
                        shift_d = {shift_q[6:0], i_sda};
                        cnt_d = cnt_q + 4'h1;
                    end
                    else if (scl_fall && cnt_q == 4'h8)
                    begin
                        cnt_d = 4'h0;
                        if (state_q == rtcw_pkg::ST_ADDR)
                        begin
                            // Foreign address: stay silent until next start
                            if (shift_q[7:1] == `RTCW_SLAVE_ADDR)
                            begin
                                rw_d = shift_q[0];
                                oe_d = 1'b1;
                                state_d = rtcw_pkg::ST_AACK;
                            end
                            else
                            begin
                                state_d = rtcw_pkg::ST_IDLE;
                            end
                        end
                        else if (state_q == rtcw_pkg::ST_PTR)
                        begin
                            ptr_d = shift_q[3:0];
                            oe_d = 1'b1;
                            state_d = rtcw_pkg::ST_PACK;
                        end
                        else
                        begin
                            wr_en = 1'b1;
                            oe_d = 1'b1;
                            state_d = rtcw_pkg::ST_WACK;
                        end
                    end
                end
                rtcw_pkg::ST_AACK:
                begin
                    // End of acknowledge clock
                    if (scl_fall)
                    begin
                        if (rw_q)
                        begin
                            shift_d = {rd_byte[6:0], 1'b0};
                            oe_d = ~rd_byte[7];
                            cnt_d = 4'h1;
                            state_d = rtcw_pkg::ST_RDAT;
                        end
                        else
                        begin
                            oe_d = 1'b0;
                            state_d = rtcw_pkg::ST_PTR;
                        end
                    end
                end
                rtcw_pkg::ST_PACK:
                begin
                    if (scl_fall)
                    begin
                        oe_d = 1'b0;
                        state_d = rtcw_pkg::ST_WDAT;
                    end
                end
                rtcw_pkg::ST_WACK:
                begin
                    // Auto-increment for burst writes
                    if (scl_fall)
                    begin
                        oe_d = 1'b0;
                        ptr_d = ptr_q + 4'h1;
                        state_d = rtcw_pkg::ST_WDAT;
                    end
                end
                rtcw_pkg::ST_RDAT:
                begin
                    // Change data while clock low
                    if (scl_fall)
                    begin
                        if (cnt_q == 4'h8)
                        begin
                            oe_d = 1'b0;
                            state_d = rtcw_pkg::ST_RACK;
                        end
                        else
                        begin
                            oe_d = ~shift_q[7];
                            shift_d = {shift_q[6:0], 1'b0};
                            cnt_d = cnt_q + 4'h1;
                        end
                    end
                end
                rtcw_pkg::ST_RACK:
                begin
                    // Master nack ends the read
                    if (scl_rise)
                    begin
                        if (i_sda)
                        begin
                            state_d = rtcw_pkg::ST_IDLE;
                        end
                        else
                        begin
                            ptr_d = ptr_q + 4'h1;
                        end
                    end
                    else if (scl_fall)
                    begin
                        shift_d = {rd_byte[6:0], 1'b0};
                        oe_d = ~rd_byte[7];
                        cnt_d = 4'h1;
                        state_d = rtcw_pkg::ST_RDAT;
                    end
                end
                default:
                begin
                    state_d = rtcw_pkg::ST_IDLE;
                    oe_d = 1'b0;
                end
            endcase
        end
    end

    // Serial slave registers
    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            state_q <= rtcw_pkg::ST_IDLE;
            cnt_q <= 4'h0;
            shift_q <= 8'h00;
            ptr_q <= 4'h0;
            rw_q <= 1'b0;
            oe_q <= 1'b0;
            sda_out_q <= 1'b0;
        end
        else
        begin
            scl_q <= i_scl;
            sda_q <= i_sda;
            state_q <= state_d;
            cnt_q <= cnt_d;
            shift_q <= shift_d;
            ptr_q <= ptr_d;
            rw_q <= rw_d;
            oe_q <= oe_d;
            sda_out_q <= 1'b0;
        end
    end

    // Register file next values
    always_comb
    begin
        hour_match_disable_d = hour_match_disable_q;
        hour_val_d = hour_val_q;
        day_of_month_match_disable_d = day_of_month_match_disable_q;
        date_val_d = date_val_q;
        day_of_week_match_disable_d = day_of_week_match_disable_q;
        wday_val_d = wday_val_q;
        square_wave_gate_d = square_wave_gate_q;
        square_wave_rate_select_d = square_wave_rate_select_q;
        if (wr_en)
        begin
            case (ptr_q)
                `RTCW_OFS_HOUR:
                begin
                    hour_match_disable_d = shift_q[`RTCW_DIS_BIT]; // [RULE1]
                    hour_val_d = shift_q[`RTCW_HOUR_MSB:0]; // [RULE2]
                end
                `RTCW_OFS_DATE:
                begin
                    day_of_month_match_disable_d = shift_q[`RTCW_DIS_BIT]; // [RULE3]
                    date_val_d = shift_q[`RTCW_DATE_MSB:0]; // [RULE4]
                end
                `RTCW_OFS_WDAY:
                begin
                    day_of_week_match_disable_d = shift_q[`RTCW_DIS_BIT]; // [RULE5]
                    wday_val_d = shift_q[`RTCW_WDAY_MSB:0]; // [RULE6]
                end
                `RTCW_OFS_SQW:
                begin
                    // Bits 6:2 dropped, cannot steer
                    square_wave_gate_d = shift_q[`RTCW_SQW_GATE_BIT]; // [RULE8]
                    square_wave_rate_select_d =
                        rtcw_pkg::rtcw_rate_type'(shift_q[`RTCW_RATE_MSB:0]); // [RULE10]
                end
                // Other pointers ignored
                default:
                begin
                    hour_val_d = hour_val_q;
                end
            endcase
        end
    end

    // Register file flops
    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            hour_match_disable_q <= `RTCW_RST_DIS; // [RULE1]
            hour_val_q <= `RTCW_RST_HOUR;
            day_of_month_match_disable_q <= `RTCW_RST_DIS; // [RULE3]
            date_val_q <= `RTCW_RST_DATE;
            day_of_week_match_disable_q <= `RTCW_RST_DIS; // [RULE5]
            wday_val_q <= `RTCW_RST_WDAY;
            square_wave_gate_q <= `RTCW_RST_GATE; // [RULE8]
            square_wave_rate_select_q <= rtcw_pkg::rtcw_rate_type'(`RTCW_RST_RATE); // [RULE9]
        end
        else
        begin
            hour_match_disable_q <= hour_match_disable_d;
            hour_val_q <= hour_val_d;
            day_of_month_match_disable_q <= day_of_month_match_disable_d;
            date_val_q <= date_val_d;
            day_of_week_match_disable_q <= day_of_week_match_disable_d;
            wday_val_q <= wday_val_d;
            square_wave_gate_q <= square_wave_gate_d;
            square_wave_rate_select_q <= square_wave_rate_select_d;
        end
    end

    // Alarm compare; all disabled means never, to avoid a constant alarm
    always_comb
    begin
        alarm_d = (~hour_match_disable_q | ~day_of_month_match_disable_q | ~day_of_week_match_disable_q)
            & (hour_match_disable_q | (hour_val_q == i_cur_hour))
            & (day_of_month_match_disable_q | (date_val_q == i_cur_date))
            & (day_of_week_match_disable_q | (wday_val_q == i_cur_wday)); // [RULE11]
    end

    // Alarm flop
    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            alarm_q <= 1'b0;
        end
        else
        begin
            alarm_q <= alarm_d;
        end
    end

    // Square-wave generator, registered inside
    rtcw_sqw_gen u_sqw (
        .i_ref_clk(i_ref_clk),
        .i_resetn(i_resetn),
        .i_osc(i_osc_32k),
        .i_gate(square_wave_gate_q), // [RULE7]
        .i_pin_enable(i_square_wave_pin_enable),
        .i_rate(square_wave_rate_select_q),
        .o_wave(o_square_wave_output)
    );

    assign o_sda_out = sda_out_q;
    assign o_sda_oe = oe_q;
    assign o_alarm_match = alarm_q;

endmodule : rtcw_alarm_square_wave_output

// ### testbench/rtcw_alarm_square_wave_output_props.sv
// Checker on the top ports
// Assumes scl synchronous to the clock
`timescale 1ns/10ps

module rtcw_alarm_square_wave_output_props (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic o_sda_out,
    input wire logic o_sda_oe,
    input wire logic [5:0] i_cur_hour,
    input wire logic [5:0] i_cur_date,
    input wire logic [2:0] i_cur_wday,
    input wire logic i_osc_32k,
    input wire logic i_square_wave_pin_enable,
    input wire logic o_alarm_match,
    input wire logic o_square_wave_output
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);
    logic no_bus_q, no_bus_d; // No bus yet
    logic scl_q; // Last scl level
    logic [14:0] cur_q, cur_d; // Last time inputs
    logic [2:0] quiet_q, quiet_d; // Cycles since a cause

    // Helper next state
    always_comb
    begin
        no_bus_d = no_bus_q & i_scl;
        cur_d = {i_cur_hour, i_cur_date, i_cur_wday};
        quiet_d = quiet_q + {2'h0, quiet_q != 3'h7};
        if ((scl_q & !i_scl) || cur_d != cur_q)
        begin
            quiet_d = 3'h0; // Write or time change
        end
    end

    // Helper registers
    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            no_bus_q <= 1'b1;
            scl_q <= 1'b1;
            cur_q <= 15'h0000;
            quiet_q <= 3'h0;
        end
        else
        begin
            no_bus_q <= no_bus_d;
            scl_q <= i_scl;
            cur_q <= cur_d;
            quiet_q <= quiet_d;
        end
    end

    pin_off_low_a: assert property (!i_square_wave_pin_enable |=> !o_square_wave_output)
        else $error("wave high with pin off");
    wave_rise_a: assert property (no_bus_q && $rose(i_osc_32k) |->
        ##[1:4] (o_square_wave_output || !i_square_wave_pin_enable)) else $error("wave missed a rise");
    wave_fall_a: assert property (no_bus_q && $fell(i_osc_32k) |-> ##[1:4] !o_square_wave_output)
        else $error("wave missed a fall");
    alarm_idle_a: assert property (no_bus_q |-> !o_alarm_match)
        else $error("match while all disabled");
    match_cause_a: assert property ($changed(o_alarm_match) |-> quiet_q < 3'h5)
        else $error("match moved without cause");
    sda_open_drain_a: assert property (o_sda_out == 1'b0)
        else $error("data line driven high");
    ack_hold_a: assert property (i_scl && $past(i_scl) |-> $stable(o_sda_oe))
        else $error("drive moved, clock high");
    ack_start_a: assert property ($rose(o_sda_oe) |-> !i_scl && !$past(i_scl))
        else $error("drive began, clock high");

    match_seen_c: cover property ($rose(o_alarm_match));
    ack_seen_c: cover property ($rose(o_sda_oe));
    wave_seen_c: cover property (!no_bus_q && $rose(o_square_wave_output));
endmodule : rtcw_alarm_square_wave_output_props

bind rtcw_alarm_square_wave_output rtcw_alarm_square_wave_output_props u_props (.*);

// ### testbench/rtcw_host_model.sv
// Two-wire bus master for the host
// Assumes the resolved data line comes back on i_sda
`timescale 1ns/10ps

module rtcw_host_model (
    input wire logic i_ref_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_pull
);
    int slow = 0; // Extra low-phase clocks

    // Bus idle
    initial
    begin
        o_scl = 1'b1;
        o_sda_pull = 1'b0;
    end

    // Wait n clocks, step off edge
    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask : tick

    // Start or repeated start
    task automatic start();
        o_sda_pull = 1'b0;
        tick(2);
        o_scl = 1'b1;
        tick(4);
        o_sda_pull = 1'b1;
        tick(4);
        o_scl = 1'b0;
        tick(2);
    endtask : start

    // Stop
    task automatic stop();
        o_sda_pull = 1'b1;
        tick(2);
        o_scl = 1'b1;
        tick(4);
        o_sda_pull = 1'b0;
        tick(4);
    endtask : stop

    // One bit, sampled mid high phase
    task automatic bit_io(input logic b, output logic r);
        o_sda_pull = !b;
        tick(2 + slow);
        o_scl = 1'b1;
        tick(2);
        r = i_sda;
        tick(2);
        o_scl = 1'b0;
        tick(2); // Hold data past the fall
    endtask : bit_io

    // Byte out MSB first, ack returned
    task automatic send(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(b[i], r);
        end
        bit_io(1'b1, r);
        ack = !r;
    endtask : send

    // Byte in MSB first, then ack level
    task automatic recv(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(nack, r);
    endtask : recv
endmodule : rtcw_host_model

// ### testbench/rtcw_alarm_square_wave_output_tb_top.sv
// Bench: host model on the bus, random settings
// Assumes design, checker, host model compiled first
`timescale 1ns/10ps
`include "rtcw_map.svh"

module rtcw_alarm_square_wave_output_tb_top;
    logic i_ref_clk, i_resetn, i_osc_32k, pin_en, scl, pull, sda_oe, sda_out, match, sqw;
    logic [5:0] cur_hour, cur_date;
    logic [2:0] cur_wday;
    logic [31:0] lfsr_q = 32'hf17c_010c; // Fixed seed
    logic [7:0] msk [4] = '{8'hbf, 8'hbf, 8'h87, 8'h83}; // Bits kept per register
    int miscompares = 0;
    int cmp_count = 0;
    wire sda = !(pull | (sda_oe & !sda_out)); // Pulled up, either side sinks

    rtcw_alarm_square_wave_output dut (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_scl(scl), .i_sda(sda),
        .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_cur_hour(cur_hour), .i_cur_date(cur_date),
        .i_cur_wday(cur_wday), .i_osc_32k(i_osc_32k), .i_square_wave_pin_enable(pin_en),
        .o_alarm_match(match), .o_square_wave_output(sqw));
    rtcw_host_model host (.i_ref_clk(i_ref_clk), .i_sda(sda), .o_scl(scl), .o_sda_pull(pull));

    // 10 MHz reference
    initial
    begin
        i_ref_clk = 1'b0;
        forever #50 i_ref_clk = !i_ref_clk;
    end

    // Oscillator, 306 clocks a period
    initial
    begin
        i_osc_32k = 1'b0;
        forever
        begin
            repeat (153) @(posedge i_ref_clk);
            #1 i_osc_32k = !i_osc_32k;
        end
    end

    // Next pseudo-random word
    function logic [31:0] rnd();
        lfsr_q = {lfsr_q[30:0], ^(lfsr_q & 32'h8020_0003)};
        return lfsr_q;
    endfunction : rnd

    // Two BCD digits
    function automatic logic [5:0] bcd(input int n);
        return 6'((n / 10) * 16 + n % 10);
    endfunction : bcd

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: register read %h, expected %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk1(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: output level %b, expected %b", $time, got, exp);
        end
    endtask : chk1

    task automatic chkn(input int got, input int lo, input int hi);
        cmp_count++;
        if (got < lo || got > hi)
        begin
            miscompares++;
            $display("Error at %0t: %0d wave rises, expected %0d to %0d", $time, got, lo, hi);
        end
    endtask : chkn

    // Count wave rises
    task automatic edges(input int win, output int c);
        logic last;
        c = 0;
        last = sqw;
        repeat (win)
        begin
            host.tick(1);
            c += int'(sqw & !last);
            last = sqw;
        end
    endtask : edges

    // Register write
    task automatic wr(input logic [7:0] p, input logic [7:0] v);
        logic a;
        host.start();
        host.send({`RTCW_SLAVE_ADDR, 1'b0}, a);
        host.send(p, a);
        host.send(v, a);
        host.stop();
    endtask : wr

    // Register read: pointer, repeated start, nack
    task automatic rd(input logic [7:0] p, output logic [7:0] v);
        logic a;
        host.start();
        host.send({`RTCW_SLAVE_ADDR, 1'b0}, a);
        host.send(p, a);
        host.start();
        host.send({`RTCW_SLAVE_ADDR, 1'b1}, a);
        host.recv(1'b1, v);
        host.stop();
    endtask : rd

    // Reset contents of all four
    task automatic resets();
        logic [7:0] v;
        for (int i = 10; i < 14; i++)
        begin
            rd(8'(i), v);
            chk8(v, 8'h80);
        end
    endtask : resets

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
        begin
            $display("DONE - PASS");
        end
        else
        begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done

    // Watchdog past the expected 52k to 54k clocks
    initial
    begin
        repeat (90000) @(posedge i_ref_clk);
        miscompares++;
        test_done();
    end

    // Main sequence
    initial
    begin
        logic [7:0] v, val;
        logic [31:0] r;
        logic e;
        int n, c, lo, hn, dn, wn;
        i_resetn = 1'b0;
        pin_en = 1'b1;
        cur_hour = 6'h00;
        cur_date = 6'h00;
        cur_wday = 3'h0;
        repeat (2) @(posedge i_ref_clk);
        #1 i_resetn = 1'b1;
        host.tick(2);
        chk1(match, 1'b0);
        edges(3060, c);
        chkn(c, 10, 11);
        resets();
        $display("Test reset state done");
        for (int i = 0; i < 8; i++)
        begin
            r = rnd();
            host.slow = int'(r[9:8]);
            val = (i % 4 == 0) ? {r[7:6], bcd(r[15:8] % 24)} : (i % 4 == 1) ? {r[7:6], bcd(r[15:8] % 31 + 1)}
                : (i % 4 == 2) ? {r[7:3], 3'(r[15:8] % 7)} : r[7:0];
            wr(8'(10 + i % 4), val);
            rd(8'(10 + i % 4), v);
            chk8(v, val & msk[i % 4]);
        end
        wr(8'h05, r[7:0]); // Unmapped pointer
        rd(8'h05, v);
        chk8(v, 8'h00);
        host.slow = 0;
        $display("Test register fields done");
        hn = int'(rnd() % 24);
        dn = int'(rnd() % 31) + 1;
        wn = int'(rnd() % 7);
        for (int m = 0; m < 8; m++)
        begin
            wr(8'h0a, {!m[0], 1'b0, bcd(hn)});
            wr(8'h0b, {!m[1], 1'b0, bcd(dn)});
            wr(8'h0c, {!m[2], 4'h0, 3'(wn)});
            for (int f = 0; f < 4; f++)
            begin
                cur_hour = bcd(f == 1 ? (hn + 1) % 24 : hn);
                cur_date = bcd(f == 2 ? dn % 31 + 1 : dn);
                cur_wday = 3'(f == 3 ? (wn + 1) % 7 : wn);
                host.tick(3);
                e = m != 0 && !(m[0] && f == 1) && !(m[1] && f == 2) && !(m[2] && f == 3);
                chk1(match, e);
            end
        end
        $display("Test alarm match done");
        for (int k = 0; k < 4; k++)
        begin
            r = rnd();
            wr(8'h0d, {1'b1, r[4:0], 2'(k)});
            n = (k == 1) ? 19584 : (k == 0) ? 3060 : 4000;
            lo = n / (306 << (5 * k));
            host.tick(20);
            edges(n, c);
            chkn(c, lo, lo + 1);
        end
        wr(8'h0d, {1'b0, r[4:0], 2'h0});
        host.tick(5);
        edges(1000, c);
        chkn(c, 0, 0);
        chk1(sqw, 1'b0);
        wr(8'h0d, 8'h80);
        pin_en = 1'b0;
        edges(1000, c);
        chkn(c, 0, 0);
        chk1(sqw, 1'b0);
        pin_en = 1'b1;
        edges(1000, c);
        chkn(c, 3, 4);
        $display("Test square wave done");
        i_resetn = 1'b0;
        host.tick(2);
        i_resetn = 1'b1;
        host.tick(2);
        resets();
        $display("Test second reset done");
        test_done();
    end
endmodule : rtcw_alarm_square_wave_output_tb_top
